// ---- src/nfp_host.sv ----
// Host controller for programming and querying an asynchronous parallel NOR flash.
// Assumes one flash on a byte bus; software drives the plain register port.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
module nfp_host import nfp_pkg::*; #(
  parameter int AW = 24,
  parameter int POLL_LIMIT = POLL_MAX
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Interrupt
  output logic irq,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [AW-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in
);
  nfp_state_t st_r, st_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [7:0] wdat_r, wdat_nxt, dq_r, dq_nxt, sr_r, sr_nxt, rdat_r, rdat_nxt;
  logic [2:0] op_r, op_nxt;
  logic [2:0] irq_st_r, irq_st_nxt, mask_r, mask_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [31:0] poll_r, poll_nxt;
  logic [7:0] dqin_r, dqin_nxt;
  logic ce_r, ce_nxt, dqoe_r, dqoe_nxt, irq_r, irq_nxt;
  logic bc_start, bc_write, bc_busy, bc_done, bc_oe_n, bc_we_n;
  logic [2:0] ev;

  // One flash bus cycle at a time
  nfp_bus_cycle #(.PHASE(PHASE_CYC)) u_cyc (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(bc_start),
    .is_write(bc_write),
    .busy(bc_busy),
    .done(bc_done),
    .oe_n(bc_oe_n),
    .we_n(bc_we_n)
  );

  function automatic logic sr_error(input logic [7:0] s);
    sr_error = s[SB_FAIL] | s[SB_SUPPLY] | s[SB_LOCKED];
  endfunction : sr_error

  // Sequencer
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    dq_nxt = dq_r;
    sr_nxt = sr_r;
    rdat_nxt = rdat_r;
    op_nxt = op_r;
    poll_nxt = poll_r;
    ce_nxt = ce_r;
    dqoe_nxt = dqoe_r;
    // Read data taken while output enable is still low; the bus is invalid once released
    dqin_nxt = bc_oe_n ? dqin_r : flash_dq_in;
    bc_start = 1'b0;
    bc_write = 1'b0;
    ev = 3'b000;
    if (reg_wr && reg_addr == RG_ADDR && st_r == ST_IDLE) addr_nxt = reg_wdata[AW-1:0];
    if (reg_wr && reg_addr == RG_DATA && st_r == ST_IDLE) wdat_nxt = reg_wdata[7:0];
    unique case (st_r)
      ST_IDLE: begin
        ce_nxt = 1'b0;
        dqoe_nxt = 1'b1;
        if (reg_wr && reg_addr == RG_CTRL && reg_wdata[2:0] != 3'h0) begin
          op_nxt = reg_wdata[2:0];
          ce_nxt = 1'b1;
          st_nxt = ST_WR1;
        end
      end
      ST_WR1: begin
        // First write: command code on the bus
        dqoe_nxt = 1'b0;
        unique case (op_r)
          OP_PROG: dq_nxt = CMD_PROG_SETUP;
          OP_CLEAR: dq_nxt = CMD_CLR_STAT;
          OP_ARRAY: dq_nxt = CMD_READ_ARRAY;
          OP_QUERY: dq_nxt = CMD_QUERY;
          default: dq_nxt = CMD_READ_STAT;
        endcase
        if (!bc_busy && !bc_done && dqoe_r == 1'b0) begin
          bc_start = 1'b1;
          bc_write = 1'b1;
        end
        if (bc_done) begin
          if (op_r == OP_PROG) begin
            dq_nxt = wdat_r;
            st_nxt = ST_WR2;
          end else if (op_r == OP_QUERY || op_r == OP_READ) begin
            dqoe_nxt = 1'b1;
            st_nxt = ST_RD;
          end else begin
            st_nxt = ST_DONE;
          end
        end
      end
      ST_WR2: begin
        // Second write: data to the same location
        if (!bc_busy && !bc_done) begin
          bc_start = 1'b1;
          bc_write = 1'b1;
        end
        if (bc_done) begin
          dqoe_nxt = 1'b1;
          poll_nxt = 32'h0000_0000;
          st_nxt = ST_POLL;
        end
      end
      ST_POLL: begin
        // Each read pulses output enable high-low-high, refreshing status
        if (!bc_busy && !bc_done) bc_start = 1'b1;
        if (bc_done) begin
          sr_nxt = dqin_r;
          poll_nxt = poll_r + 32'h0000_0001;
          if (dqin_r[SB_READY]) st_nxt = ST_CHECK;
          else if (poll_r >= 32'(POLL_LIMIT)) begin
            ev[IRQ_TMO] = 1'b1;
            st_nxt = ST_DONE;
          end else st_nxt = ST_GAP;
        end
      end
      ST_GAP: st_nxt = ST_POLL;
      ST_CHECK: begin
        // Full check after each program that reads ready before the poll limit; error bits are sticky on the flash
        if (sr_error(sr_r)) ev[IRQ_ERR] = 1'b1;
        st_nxt = ST_DONE;
      end
      ST_RD: begin
        if (!bc_busy && !bc_done) bc_start = 1'b1;
        if (bc_done) begin
          rdat_nxt = dqin_r;
          if (op_r == OP_READ) sr_nxt = dqin_r;
          st_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        ce_nxt = 1'b0;
        dqoe_nxt = 1'b1;
        ev[IRQ_DONE] = 1'b1;
        op_nxt = 3'h0;
        st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      addr_r <= '0;
      wdat_r <= RST_ZERO8;
      dq_r <= RST_ZERO8;
      sr_r <= RST_ZERO8;
      rdat_r <= RST_ZERO8;
      op_r <= 3'h0;
      poll_r <= 32'h0000_0000;
      dqin_r <= RST_ZERO8;
      ce_r <= 1'b0;
      dqoe_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      dq_r <= dq_nxt;
      sr_r <= sr_nxt;
      rdat_r <= rdat_nxt;
      op_r <= op_nxt;
      poll_r <= poll_nxt;
      dqin_r <= dqin_nxt;
      ce_r <= ce_nxt;
      dqoe_r <= dqoe_nxt;
    end
  end

  // Register read, interrupt status and mask; event wins over read-clear
  always_comb begin
    irq_st_nxt = irq_st_r | ev;
    mask_nxt = mask_r;
    rd_nxt = 32'h0000_0000;
    if (reg_wr && reg_addr == RG_MASK) mask_nxt = reg_wdata[2:0];
    if (reg_rd) begin
      unique case (reg_addr)
        RG_CTRL: rd_nxt = {28'h0, st_r == ST_IDLE ? 1'b0 : 1'b1, op_r};
        RG_ADDR: rd_nxt = 32'(addr_r);
        RG_DATA: rd_nxt = {24'h0, wdat_r};
        // Flash status: ready, fail, supply, locked bits as read
        RG_STAT: rd_nxt = {24'h0, sr_r};
        RG_IRQ: begin
          rd_nxt = {29'h0, irq_st_r};
          irq_st_nxt = ev;
        end
        RG_MASK: rd_nxt = {29'h0, mask_r};
        // Query byte or status byte of last read
        RG_RDATA: rd_nxt = {24'h0, rdat_r};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
    irq_nxt = |(irq_st_nxt & mask_nxt);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_st_r <= 3'h0;
      mask_r <= 3'h0;
      rd_r <= 32'h0000_0000;
      irq_r <= 1'b0;
    end else begin
      irq_st_r <= irq_st_nxt;
      mask_r <= mask_nxt;
      rd_r <= rd_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Pin outputs; strobes come from the cycle timer flops
  assign reg_rdata = rd_r;
  assign irq = irq_r;
  assign flash_ce_n = !ce_r;
  assign flash_oe_n = bc_oe_n;
  assign flash_we_n = bc_we_n;
  assign flash_addr = addr_r;
  assign flash_dq_out = dq_r;
  assign flash_dq_oe = dqoe_r;

  chk_prog_setup_code: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r == ST_WR1 && op_r == OP_PROG && bc_start) |-> dq_r == CMD_PROG_SETUP)
    else $error("program setup code not on bus");
  chk_prog_data_same: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r == ST_WR2 && bc_start) |-> dq_r == wdat_r && $stable(addr_r))
    else $error("program data write wrong");
  chk_poll_until_ready: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r == ST_POLL && bc_done && !dqin_r[SB_READY] && poll_r < 32'(POLL_LIMIT)) |=> st_r == ST_GAP)
    else $error("poll stopped while busy");
  chk_ready_ends_poll: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r == ST_POLL && bc_done && dqin_r[SB_READY]) |=> st_r == ST_CHECK ##1 st_r == ST_DONE)
    else $error("ready not taken");
  chk_oe_toggle_poll: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r == ST_POLL && bc_start) |=> !flash_oe_n)
    else $error("poll read without oe low");
  chk_err_event: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r == ST_CHECK && sr_error(sr_r)) |=> irq_st_r[IRQ_ERR])
    else $error("error flag not reported");
  chk_array_code: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r == ST_WR1 && op_r == OP_ARRAY && bc_start) |-> dq_r == CMD_READ_ARRAY)
    else $error("read array code wrong");
  chk_clear_code: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_r == ST_WR1 && op_r == OP_CLEAR && bc_start) |-> dq_r == CMD_CLR_STAT)
    else $error("clear status code wrong");
  chk_dq_drive_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    !flash_we_n |-> !flash_dq_oe && !flash_ce_n)
    else $error("write strobe without drive");
endmodule : nfp_host

// ---- src/nfp_pkg.sv ----
// Package for the NOR flash program/query host controller.
// Assumes a 100 MHz ref_clk and an asynchronous parallel flash on the far side.
package nfp_pkg;
  // Flash command codes
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STAT = 8'h70;
  localparam logic [7:0] CMD_CLR_STAT = 8'h50;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  // Status bit positions
  localparam int SB_READY = 7;
  localparam int SB_FAIL = 4;
  localparam int SB_SUPPLY = 3;
  localparam int SB_LOCKED = 1;
  // Query addresses
  localparam logic [7:0] QA_PROT_FIELDS = 8'h3f;
  localparam logic [7:0] QA_PROT_LOW = 8'h40;
  localparam logic [7:0] QA_PAGE = 8'h44;
  localparam logic [7:0] QA_BURST = 8'h45;
  // Host registers (word index = byte offset / 4)
  localparam logic [3:0] RG_CTRL = 4'h0;
  localparam logic [3:0] RG_ADDR = 4'h1;
  localparam logic [3:0] RG_DATA = 4'h2;
  localparam logic [3:0] RG_STAT = 4'h3;
  localparam logic [3:0] RG_IRQ = 4'h4;
  localparam logic [3:0] RG_MASK = 4'h5;
  localparam logic [3:0] RG_RDATA = 4'h6;
  // Control opcodes written to RG_CTRL
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_CLEAR = 3'h2;
  localparam logic [2:0] OP_ARRAY = 3'h3;
  localparam logic [2:0] OP_QUERY = 3'h4;
  localparam logic [2:0] OP_READ = 3'h5;
  // Bus phase timing
  localparam int T_PHASE_NS = 70;
  localparam int CLK_NS = 10;
  localparam int PHASE_CYC = (T_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int POLL_MAX = 100000;
  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_TMO = 2;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_WR1 = 4'h1, ST_WR2 = 4'h2, ST_POLL = 4'h3, ST_GAP = 4'h4,
    ST_CHECK = 4'h5, ST_RD = 4'h6, ST_DONE = 4'h7
  } nfp_state_t;
endpackage : nfp_pkg

// ---- src/nfp_bus_cycle.sv ----
// One asynchronous flash bus cycle, write or read, stretched to a phase count.
// Assumes the flash meets its access time within PHASE_CYC clock cycles.
`timescale 1ns/1ns
module nfp_bus_cycle import nfp_pkg::*; #(
  parameter int PHASE = PHASE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Request
  input wire logic start,
  input wire logic is_write,
  output logic busy,
  output logic done,
  // Strobes (active low)
  output logic oe_n,
  output logic we_n
);
  logic [7:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt, wr_r, wr_nxt, done_r, done_nxt;
  logic oe_r, oe_nxt, we_r, we_nxt;

  // Phase counter and strobe control
  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    wr_nxt = wr_r;
    done_nxt = 1'b0;
    if (!run_r && start) begin
      run_nxt = 1'b1;
      wr_nxt = is_write;
      cnt_nxt = 8'(PHASE);
    end else if (run_r) begin
      if (cnt_r == 8'h00) begin
        run_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 8'h01;
      end
    end
    // Strobes registered from the next state; write strobe released in the last count, output enable when the cycle ends
    we_nxt = !(run_nxt && wr_nxt && cnt_nxt != 8'h00);
    oe_nxt = !(run_nxt && !wr_nxt);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 8'h00;
      run_r <= 1'b0;
      wr_r <= 1'b0;
      done_r <= 1'b0;
      oe_r <= 1'b1;
      we_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      wr_r <= wr_nxt;
      done_r <= done_nxt;
      oe_r <= oe_nxt;
      we_r <= we_nxt;
    end
  end

  // Write strobe low while running, released in the last count so data hold is met; output enable released when the cycle ends
  assign busy = run_r;
  assign done = done_r;
  assign we_n = we_r;
  assign oe_n = oe_r;
endmodule : nfp_bus_cycle

// ---- tb/nfp_flash_model.sv ----
// Behavioural flash: command decode, engine, status and query table.
// Assumes host strobes change just after ref_clk edges.
`timescale 1ns/1ns
module nfp_flash_model (
  // Clock
  input wire logic ref_clk,
  // Flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [23:0] addr,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  output logic [7:0] dq_in,
  // Fault and delay control
  input wire logic [2:0] err_inj,
  input wire logic [15:0] busy_cyc
);
  logic [7:0] mem [256];
  logic [7:0] sts = 8'h80;
  logic [7:0] snap = 8'h80;
  logic [7:0] last = 8'h00;
  logic [1:0] mode = 2'h0;
  logic armed = 1'b0;
  logic we_q = 1'b1;
  logic oe_q = 1'b1;
  int cnt = 0;
  // Query table
  function automatic logic [7:0] qtab(input logic [7:0] a);
    case (a)
      8'h3f: return 8'h01;
      8'h40: return 8'h80;
      8'h42, 8'h43: return 8'h03;
      8'h44: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction : qtab
  // Commands, engine and status
  always @(posedge ref_clk) begin
    we_q <= we_n;
    oe_q <= oe_n;
    if (!ce_n && !oe_n) last <= dq_in;
    if (oe_q && !oe_n) snap <= sts;
    if (cnt > 0) cnt <= cnt - 1;
    if (cnt == 1) sts <= sts | {3'h4, err_inj[2], err_inj[1], 1'b0, err_inj[0], 1'b0};
    if (!we_q && we_n && !ce_n && !dq_oe) begin
      if (armed) begin
        armed <= 1'b0;
        if (err_inj[1:0] == 2'h0) mem[addr[7:0]] <= dq_out;
        sts[7] <= 1'b0;
        cnt <= busy_cyc;
      end else begin
        case (dq_out)
          8'h40: begin armed <= 1'b1; mode <= 2'h1; end
          8'h50: sts <= sts & 8'he5;
          8'h70: mode <= 2'h1;
          8'h98: mode <= 2'h2;
          8'hff: mode <= 2'h0;
          default: ;
        endcase
      end
    end
  end
  // Read path; a released bus shows the inverse of the last value
  assign dq_in = (ce_n || oe_n) ? ~last : (mode == 2'h0) ? mem[addr[7:0]] : (mode == 2'h1) ? snap : qtab(addr[7:0]);
endmodule : nfp_flash_model

// ---- tb/nfp_host_test.sv ----
// Self-checking bench for the flash program/query host.
// Assumes the behavioural flash model stands on the far side.
`timescale 1ns/1ns
module nfp_host_test;
  import nfp_pkg::*;
  logic ref_clk, nrst, reg_wr, reg_rd, irq, ce_n, oe_n, we_n, dq_oe;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [23:0] f_addr;
  logic [7:0] dq_out, dq_in;
  logic [2:0] err_inj;
  logic [15:0] busy_cyc;
  int error_cnt = 0;
  int cmp_count = 0;
  localparam logic [7:0] EBIT [3] = '{8'h02, 8'h08, 8'h10};
  localparam logic [7:0] QEXP [7] = '{8'h01, 8'h80, 8'h00, 8'h03, 8'h03, 8'h03, 8'h00};
  nfp_host #(.AW(24), .POLL_LIMIT(200)) i_nfp_host (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(f_addr), .flash_dq_out(dq_out),
    .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
  nfp_flash_model i_nfp_flash_model (.ref_clk(ref_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .err_inj(err_inj), .busy_cyc(busy_cyc));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task check_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task check_pin(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t pin %b expected %b", $time, got, exp);
    end
  endtask : check_pin
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // Start an operation, wait until idle, return the event status
  task run(input logic [2:0] op, output logic [31:0] v);
    wr(RG_CTRL, {29'h0, op});
    for (int i = 0; i < 3000; i++) begin
      rd(RG_CTRL, v);
      if (v[3] === 1'b0) break;
    end
    check_pin(v[3], 1'b0);
    rd(RG_IRQ, v);
  endtask : run
  task t_program;
    wr(RG_MASK, 32'h7);
    wr(RG_ADDR, 32'h10);
    wr(RG_DATA, 32'ha5);
    run(OP_PROG, d);
    check_val(d, 32'h1);
    check_val({24'h0, i_nfp_flash_model.mem[8'h10]}, 32'ha5);
    rd(RG_STAT, d);
    check_val(d, 32'h80);
  endtask : t_program
  task t_errors;
    for (int k = 0; k < 3; k++) begin
      err_inj <= 3'(1 << k);
      run(OP_PROG, d);
      check_val(d, 32'h3);
      err_inj <= 3'h0;
      run(OP_PROG, d);
      rd(RG_STAT, d);
      check_val(d, {24'h0, 8'h80 | EBIT[k]});
      run(OP_CLEAR, d);
      run(OP_READ, d);
      rd(RG_STAT, d);
      check_val(d, 32'h80);
    end
  endtask : t_errors
  task t_timeout;
    busy_cyc <= 16'd3000;
    run(OP_PROG, d);
    check_val(d & 32'h4, 32'h4);
    repeat (3000) @(posedge ref_clk);
    busy_cyc <= 16'd30;
  endtask : t_timeout
  task t_query;
    for (int k = 0; k < 7; k++) begin
      wr(RG_ADDR, 32'h3f + k);
      run(OP_QUERY, d);
      rd(RG_RDATA, d);
      check_val(d, {24'h0, QEXP[k]});
    end
    run(OP_ARRAY, d);
    check_val({30'h0, i_nfp_flash_model.mode}, 32'h0);
  endtask : t_query
  task t_irq;
    wr(RG_MASK, 32'h0);
    wr(RG_CTRL, {29'h0, OP_READ});
    repeat (100) @(posedge ref_clk);
    #1 check_pin(irq, 1'b0);
    wr(RG_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1 check_pin(irq, 1'b1);
    rd(RG_IRQ, d);
    check_val(d, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1 check_pin(irq, 1'b0);
    rd(RG_MASK, d);
    check_val(d, 32'h1);
    rd(4'hf, d);
    check_val(d, 32'h0);
  endtask : t_irq
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // Main sequence
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    err_inj = 3'h0;
    busy_cyc = 16'd30;
    repeat (6) @(posedge ref_clk);
    check_pin(ce_n, 1'b1);
    check_pin(dq_oe, 1'b1);
    nrst <= 1'b1;
    t_program();
    t_errors();
    t_timeout();
    t_query();
    t_irq();
    test_done();
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    test_done();
  end
endmodule : nfp_host_test
